/* design/hps_map.vh */
// Purpose: offsets, field positions and reset values of the hot-plug slot registers
// Assumes: byte offsets on a plain register port, data in the low bits of a 32-bit word
// Notes:   definitions only
`ifndef HPS_MAP_VH
`define HPS_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define HPS_ADDR_W          8
`define HPS_OFF_SLOT_CTL    8'h58
`define HPS_OFF_SLOT_STS    8'h5A
`define HPS_OFF_DEV_CAP2    8'h64
`define HPS_OFF_DEV_CTL2    8'h68
`define HPS_OFF_DEV_STS2    8'h6A
`define HPS_OFF_IRQ_STS     8'h80
`define HPS_OFF_IRQ_MASK    8'h84

// ************************************************************
// slot control fields
// ************************************************************
`define HPS_CTL_BUTTON_EN   0
`define HPS_CTL_FAULT_EN    1
`define HPS_CTL_LATCH_EN    2
`define HPS_CTL_PRESENT_EN  3
`define HPS_CTL_CMD_EN      4
`define HPS_CTL_MASTER_EN   5
`define HPS_CTL_INTERLOCK   11
`define HPS_CTL_LINK_EN     12
`define HPS_CTL_RESET       16'h0000

// ************************************************************
// slot status fields
// ************************************************************
`define HPS_STS_BUTTON      0
`define HPS_STS_FAULT       1
`define HPS_STS_LATCH_CHG   2
`define HPS_STS_PRESENT_CHG 3
`define HPS_STS_CMD_DONE    4
`define HPS_STS_LATCH       5
`define HPS_STS_PRESENT     6
`define HPS_STS_INTERLOCK   7
`define HPS_STS_LINK_CHG    8
`define HPS_EVT_W           6
`define HPS_EVT_RESET       6'h00
`define HPS_LATCH_RESET     1'h0
`define HPS_PRESENT_RESET   1'h1
`define HPS_INTERLOCK_RESET 1'h0
`define HPS_RSVD_VALUE      32'h00000000

`endif

/* design/hps_sync.v */
// Purpose: two-flop synchroniser for slot pins, one per bit
// Assumes: pins are asynchronous to CORE_CLK
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module hps_sync #(
  parameter       WIDTH    = 4,
  parameter [3:0] RST_BITS = 4'h0
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // pins in, synchronised out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ************************************************************
  // per-bit two-stage chain
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1_ff;
      reg stage2_ff;
      always @(posedge clk) begin
        if (rst) begin
          stage1_ff <= RST_BITS[i];
          stage2_ff <= RST_BITS[i];
        end else begin
          stage1_ff <= async_in[i];
          stage2_ff <= stage1_ff;
        end
      end
      assign sync_out[i] = stage2_ff;
    end
  endgenerate

endmodule

/* design/hps_slot_regs.v */
// Purpose: hot-plug slot control, slot status and reserved device registers
// Assumes: one clock CORE_CLK, synchronous RST, plain register port with read data next cycle
// Notes:   slot pins are synchronised here; command done and link active come from core logic
`timescale 1ns/1ns
`include "hps_map.vh"
module hps_slot_regs (
  // clock and reset
  input  wire        CORE_CLK,
  input  wire        RST,
  // register port
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output wire [31:0] RDATA,
  // slot pins
  input  wire        BUTTON_PRESS,
  input  wire        POWER_FAULT,
  input  wire        LATCH_OPEN,
  input  wire        CARD_PRESENT,
  // core logic on CORE_CLK
  input  wire        CMD_DONE,
  input  wire        LINK_ACTIVE,
  input  wire        CAP_INTERLOCK,
  // slot outputs
  output wire        INTERLOCK_ENGAGE,
  output wire        HOTPLUG_EVENT,
  output wire        IRQ
);

  // ************************************************************
  // address decode
  // ************************************************************
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire wr_ctl  = WR & hit(ADDR, `HPS_OFF_SLOT_CTL);
  wire wr_sts  = WR & hit(ADDR, `HPS_OFF_SLOT_STS);
  wire wr_mask = WR & hit(ADDR, `HPS_OFF_IRQ_MASK);
  wire rd_irq  = RD & hit(ADDR, `HPS_OFF_IRQ_STS);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire [2:0] pin_sync;

  hps_sync #(
    .WIDTH    (3),
    .RST_BITS ({1'b0, `HPS_PRESENT_RESET, `HPS_LATCH_RESET, 1'b0})
  ) u_sync (
    .clk      (CORE_CLK),
    .rst      (RST),
    .async_in ({CARD_PRESENT, LATCH_OPEN, BUTTON_PRESS}),
    .sync_out (pin_sync)
  );

  wire fault_sync;

  hps_sync #(
    .WIDTH    (1),
    .RST_BITS (4'h0)
  ) u_sync_fault (
    .clk      (CORE_CLK),
    .rst      (RST),
    .async_in (POWER_FAULT),
    .sync_out (fault_sync)
  );

  wire button_sync  = pin_sync[0];
  wire latch_sync   = pin_sync[1];
  wire present_sync = pin_sync[2];

  // ************************************************************
  // edge detection
  // ************************************************************
  reg button_prev_ff;
  reg fault_prev_ff;
  reg latch_prev_ff;
  reg present_prev_ff;
  reg link_prev_ff;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      button_prev_ff  <= 1'b0;
      fault_prev_ff   <= 1'b0;
      latch_prev_ff   <= `HPS_LATCH_RESET;
      present_prev_ff <= `HPS_PRESENT_RESET;
      link_prev_ff    <= 1'b0;
    end else begin
      button_prev_ff  <= button_sync;
      fault_prev_ff   <= fault_sync;
      latch_prev_ff   <= latch_sync;
      present_prev_ff <= present_sync;
      link_prev_ff    <= LINK_ACTIVE;
    end
  end

  // event vector: button, fault, latch, presence, command, link
  wire [`HPS_EVT_W-1:0] evt;
  assign evt[0] = button_sync & ~button_prev_ff;
  assign evt[1] = fault_sync & ~fault_prev_ff;
  assign evt[2] = latch_sync ^ latch_prev_ff;
  assign evt[3] = present_sync ^ present_prev_ff;
  assign evt[4] = CMD_DONE;
  assign evt[5] = LINK_ACTIVE ^ link_prev_ff;

  // ************************************************************
  // slot control
  // ************************************************************
  reg  [5:0] evt_en_ff;
  reg        link_en_ff;
  reg        interlock_ff;
  wire [5:0] nxt_evt_en;
  wire       nxt_link_en;
  wire       nxt_interlock;
  wire       toggle_req;

  assign nxt_evt_en  = wr_ctl ? WDATA[5:0] : evt_en_ff;
  assign nxt_link_en = wr_ctl ? WDATA[`HPS_CTL_LINK_EN] : link_en_ff;
  // toggle only with the capability present and a one written
  assign toggle_req    = wr_ctl & WDATA[`HPS_CTL_INTERLOCK] & CAP_INTERLOCK;
  assign nxt_interlock = interlock_ff ^ toggle_req;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      evt_en_ff    <= `HPS_EVT_RESET;
      link_en_ff   <= 1'b0;
      interlock_ff <= `HPS_INTERLOCK_RESET;
    end else begin
      evt_en_ff    <= nxt_evt_en;
      link_en_ff   <= nxt_link_en;
      interlock_ff <= nxt_interlock;
    end
  end

  // ************************************************************
  // slot status flags
  // ************************************************************
  reg  [`HPS_EVT_W-1:0] flag_ff;
  wire [`HPS_EVT_W-1:0] flag_clr;
  wire [`HPS_EVT_W-1:0] nxt_flag;

  assign flag_clr = wr_sts ? {WDATA[`HPS_STS_LINK_CHG], WDATA[4:0]} : `HPS_EVT_RESET;
  // a new event wins over a clear in the same cycle
  assign nxt_flag = (flag_ff & ~flag_clr) | evt;

  always @(posedge CORE_CLK) begin
    if (RST) begin
      flag_ff <= `HPS_EVT_RESET;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // ************************************************************
  // hot-plug event and local interrupt
  // ************************************************************
  reg  [`HPS_EVT_W-1:0] irq_sts_ff;
  reg  [`HPS_EVT_W-1:0] irq_mask_ff;
  reg                   hp_event_ff;
  reg                   irq_ff;
  wire [`HPS_EVT_W-1:0] nxt_irq_sts;
  wire [`HPS_EVT_W-1:0] nxt_irq_mask;
  wire [`HPS_EVT_W-1:0] flag_en;
  wire                  nxt_hp_event;
  wire                  nxt_irq;

  assign flag_en      = {link_en_ff, evt_en_ff[4:0]};
  assign nxt_hp_event = evt_en_ff[`HPS_CTL_MASTER_EN] & (|(flag_ff & flag_en));
  assign nxt_irq_sts  = (rd_irq ? `HPS_EVT_RESET : irq_sts_ff) | evt;
  assign nxt_irq_mask = wr_mask ? WDATA[`HPS_EVT_W-1:0] : irq_mask_ff;
  assign nxt_irq      = |(nxt_irq_sts & nxt_irq_mask);

  always @(posedge CORE_CLK) begin
    if (RST) begin
      irq_sts_ff  <= `HPS_EVT_RESET;
      irq_mask_ff <= `HPS_EVT_RESET;
      hp_event_ff <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      irq_sts_ff  <= nxt_irq_sts;
      irq_mask_ff <= nxt_irq_mask;
      hp_event_ff <= nxt_hp_event;
      irq_ff      <= nxt_irq;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  wire [15:0] ctl_word;
  wire [15:0] sts_word;

  // interlock control bit never reads back
  assign ctl_word = {3'h0, link_en_ff, 1'b0, 5'h00, evt_en_ff};
  assign sts_word = {7'h00,
                     flag_ff[5],
                     interlock_ff & CAP_INTERLOCK,
                     present_sync,
                     latch_sync,
                     flag_ff[4:0]};

  always @* begin
    nxt_rdata = rdata_ff;
    if (RD) begin
      case (ADDR)
        `HPS_OFF_SLOT_CTL: nxt_rdata = {16'h0000, ctl_word};
        `HPS_OFF_SLOT_STS: nxt_rdata = {16'h0000, sts_word};
        `HPS_OFF_IRQ_STS:  nxt_rdata = {26'h0, irq_sts_ff};
        `HPS_OFF_IRQ_MASK: nxt_rdata = {26'h0, irq_mask_ff};
        default:           nxt_rdata = `HPS_RSVD_VALUE;
      endcase
    end else begin
      nxt_rdata = `HPS_RSVD_VALUE;
    end
  end

  always @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_ff <= `HPS_RSVD_VALUE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign RDATA            = rdata_ff;
  assign INTERLOCK_ENGAGE = interlock_ff;
  assign HOTPLUG_EVENT    = hp_event_ff;
  assign IRQ              = irq_ff;

endmodule

/* tb/hps_chk.sv */
// Purpose: port checks of the hot-plug slot registers
// Assumes: read data one cycle after RD, zero otherwise
// Notes:   bound to every hps_slot_regs
`timescale 1ns/1ns
module hps_chk (
  // clock, reset and register port
  input wire        CORE_CLK,
  input wire        RST,
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  // interlock
  input wire        CAP_INTERLOCK,
  input wire        INTERLOCK_ENGAGE
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  wire ctl_wr = WR && ADDR == 8'h58;
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_toggle_reads_zero: assert property (
    $past(RD) && $past(ADDR) == 8'h58 |-> !RDATA[11])
    else $error("interlock control bit read as one");
  a_ctl_rsvd_zero: assert property (
    $past(RD) && $past(ADDR) == 8'h58 |-> RDATA[31:13] == 19'h0)
    else $error("slot control reserved bits not zero");
  a_sts_rsvd_zero: assert property (
    $past(RD) && $past(ADDR) == 8'h5A |-> RDATA[31:9] == 23'h0)
    else $error("slot status reserved bits not zero");
  a_dev_rsvd_zero: assert property (
    $past(RD) && ($past(ADDR) == 8'h64 || $past(ADDR) == 8'h68 || $past(ADDR) == 8'h6A)
    |-> RDATA == 32'h0)
    else $error("reserved device register not zero");
  a_toggle_flips: assert property (
    ctl_wr && WDATA[11] && CAP_INTERLOCK |=> INTERLOCK_ENGAGE != $past(INTERLOCK_ENGAGE))
    else $error("interlock did not toggle");
  a_zero_keeps: assert property (
    ctl_wr && !WDATA[11] && CAP_INTERLOCK |=> $stable(INTERLOCK_ENGAGE))
    else $error("interlock moved on a zero write");
  a_nocap_locked: assert property (
    ctl_wr && !CAP_INTERLOCK |=> $stable(INTERLOCK_ENGAGE))
    else $error("interlock moved without capability");
  a_sts_shows_lock: assert property (
    $past(RD) && $past(ADDR) == 8'h5A |-> RDATA[7] == $past(INTERLOCK_ENGAGE & CAP_INTERLOCK))
    else $error("interlock state bit wrong");
endmodule
bind hps_slot_regs hps_chk hps_chk_inst (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CAP_INTERLOCK(CAP_INTERLOCK),
  .INTERLOCK_ENGAGE(INTERLOCK_ENGAGE));

/* tb/hps_slot_model.sv */
// Purpose: slot button, power controller, latch and presence sensors
// Assumes: requested levels reach the pins one clock later
// Notes:   pins order button, fault, latch open, card present
`timescale 1ns/1ns
module hps_slot_model (
  // clock and requested levels
  input wire       clk,
  input wire [3:0] req,
  // slot pins
  output reg [3:0] pins
);
  initial pins = 4'h8;
  always @(posedge clk) begin
    pins <= req;
  end
endmodule

/* tb/test_hps_slot_regs.sv */
// Purpose: register sequences against the hot-plug slot registers
// Assumes: event flags settle within six clocks of a pin change
// Notes:   pins come from the slot model
`timescale 1ns/1ns
module test_hps_slot_regs;
  reg         clk, rst, wr, rd, cmd, link, cap;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  reg  [3:0]  req;
  wire [3:0]  pins;
  wire [31:0] rdata;
  wire        engage, hp_evt, irq;
  integer     num_errors, samples_checked, i;
  hps_slot_regs hps_slot_regs_inst (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .BUTTON_PRESS(pins[0]), .POWER_FAULT(pins[1]),
    .LATCH_OPEN(pins[2]), .CARD_PRESENT(pins[3]), .CMD_DONE(cmd), .LINK_ACTIVE(link),
    .CAP_INTERLOCK(cap), .INTERLOCK_ENGAGE(engage), .HOTPLUG_EVENT(hp_evt), .IRQ(irq));
  hps_slot_model hps_slot_model_inst (.clk(clk), .req(req), .pins(pins));
  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input [31:0] g, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      #1;
    end
  endtask
  task rd_reg(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk(rdata, e);
    end
  endtask
  task gap;
    begin
      repeat (6) @(posedge clk);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    {rst, wr, rd, cmd, link, cap, addr, wdata, req} = {6'h20, 8'h0, 32'h0, 4'h8};
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd_reg(8'h5A, 32'h40);
    rd_reg(8'h58, 32'h0);
    wr_reg(8'h58, 32'hFFFFFFFF);
    rd_reg(8'h58, 32'h103F);
    @(posedge clk);
    link <= ~link;
    gap;
    chk(hp_evt, 1'h1);
    rd_reg(8'h5A, 32'h140);
    for (i = 0; i < 2; i = i + 1) begin
      wr_reg(8'h5A, 32'h100);
      rd_reg(8'h5A, 32'h40);
      wr_reg(8'h58, i ? 32'h20 : 32'h1000);
      @(posedge clk);
      link <= ~link;
      gap;
      chk(hp_evt, 1'h0);
    end
    wr_reg(8'h5A, 32'h100);
    wr_reg(8'h58, 32'h0);
    $display("test enables done");
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk);
      if (i == 4) cmd <= 1'h1;
      else req[i] <= ~req[i];
      @(posedge clk);
      cmd <= 1'h0;
      if (i < 2) req[i] <= 1'h0;
      gap;
      wr_reg(8'h5A, ~(32'h1 << i));
      rd_reg(8'h5A, (32'h1 << i) | {req[3], req[2], 5'h0});
      wr_reg(8'h5A, 32'h1 << i);
      rd_reg(8'h5A, {req[3], req[2], 5'h0});
    end
    $display("test events done");
    @(posedge clk);
    cap <= 1'h1;
    wr_reg(8'h58, 32'h800);
    chk(engage, 1'h1);
    rd_reg(8'h58, 32'h0);
    rd_reg(8'h5A, 32'hA0);
    wr_reg(8'h58, 32'h0);
    chk(engage, 1'h1);
    wr_reg(8'h58, 32'h800);
    chk(engage, 1'h0);
    @(posedge clk);
    cap <= 1'h0;
    wr_reg(8'h58, 32'h800);
    chk(engage, 1'h0);
    rd_reg(8'h5A, 32'h20);
    $display("test interlock done");
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(8'(32'h64686A90 >> (i * 8)), 32'hFFFFFFFF);
      rd_reg(8'(32'h64686A90 >> (i * 8)), 32'h0);
    end
    $display("test reserved done");
    rd_reg(8'h80, 32'h3F);
    rd_reg(8'h80, 32'h0);
    wr_reg(8'h84, 32'h1);
    rd_reg(8'h84, 32'h1);
    for (i = 1; i >= 0; i = i - 1) begin
      @(posedge clk);
      req[i] <= 1'h1;
      @(posedge clk);
      req[i] <= 1'h0;
      gap;
      chk(irq, i ? 1'h0 : 1'h1);
    end
    rd_reg(8'h80, 32'h3);
    gap;
    chk(irq, 1'h0);
    $display("test interrupt done");
    test_done;
  end
endmodule
